// file: pkg/spi_frame_pkg.sv
// shared constants and types for the serial frame port
package spi_frame_pkg;

  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_W  = 16;  // bits per word on the wire
  localparam int PAY_W   = 15;  // payload above the parity bit
  localparam int STAT_W  = 14;  // primary status value width
  localparam int ERR_BIT = 14;  // error_answer_flag within the payload
  localparam int CNT_W   = 4;   // edge counters, modulo one word

  // ****************************************
  // filters and buffering
  // ****************************************
  localparam int SCK_SAMPLES = 3;   // clock and data debounce depth
  localparam int CS_SAMPLES  = 2;   // select debounce depth
  localparam int FIFO_DEPTH  = 32;  // request words held for the decoder

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [PAY_W-1:0]  PAY_RST  = 15'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
  localparam logic              PIN_IDLE = 1'b1;  // pins are pulled up

  // link side state
  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_SEL  = 1'b1
  } link_state_t;

  // odd parity bit that completes a payload
  function automatic logic odd_par(input logic [PAY_W-1:0] p);
    return ~^p;
  endfunction

endpackage

// file: pkg/stream_if.sv
// valid/ready word stream between the port and its buffer
`timescale 1ns/1ps
interface stream_if #(parameter int W = 15) ();
  logic         valid;  // word on data is offered
  logic         ready;  // taker accepts this cycle
  logic [W-1:0] data;   // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: logic/in_deglitch.sv
// two-flop synchroniser followed by an n-sample debounce filter
`timescale 1ns/1ps
module in_deglitch #(
  parameter int   N       = 3,
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_raw,
  output logic      o_level
);
  logic         sync1_r;  // first flop, read only by the second
  logic         sync2_r;  // settled sample
  logic [N-1:0] hist_r;   // last n settled samples
  logic         lvl_r;    // accepted level

  wire all_hi = &hist_r;
  wire all_lo = ~|hist_r;

  // sample every clock; accept a level only when all samples agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= RST_VAL;
      sync2_r <= RST_VAL;
      hist_r  <= {N{RST_VAL}};
      lvl_r   <= RST_VAL;
    end else begin
      sync1_r <= i_raw;
      sync2_r <= sync1_r;
      hist_r  <= {hist_r[N-2:0], sync2_r};
      if (all_hi) begin
        lvl_r <= 1'b1;
      end else if (all_lo) begin
        lvl_r <= 1'b0;
      end
    end
  end

  assign o_level = lvl_r;

  a_glitch_filter: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $changed(lvl_r) |-> ($past(hist_r) == {N{lvl_r}}))
    else $error("level accepted without enough equal samples");
endmodule

// file: logic/word_fifo.sv
// request word buffer with registered output and back-pressure
`timescale 1ns/1ps
module word_fifo #(
  parameter int W = 15,
  parameter int D = 32
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  stream_if.snk     s_in,
  stream_if.src     s_out
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];    // storage
  logic [AW-1:0] wr_ptr_r;   // next slot written
  logic [AW-1:0] rd_ptr_r;   // next slot read
  logic [AW:0]   count_r;    // words in storage
  logic          out_v_r;    // output stage holds a word
  logic [W-1:0]  out_d_r;    // output stage word

  // the output stage counts toward the depth, so exactly d words fit
  wire [AW:0] total = count_r + (AW+1)'(out_v_r);
  wire full  = (total == (AW+1)'(D));
  wire push  = s_in.valid & ~full;
  wire load  = (count_r != '0) & (~out_v_r | s_out.ready);
  wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(load);

  // depth is a power of two, so pointers wrap by themselves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(load);
      count_r  <= count_nxt;
    end
  end

  // storage writes
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= s_in.data;
    end
  end

  // output stage keeps the word until taken
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_v_r <= 1'b0;
      out_d_r <= '0;
    end else if (load) begin
      out_v_r <= 1'b1;
      out_d_r <= mem[rd_ptr_r];
    end else if (s_out.ready) begin
      out_v_r <= 1'b0;
    end
  end

  assign s_in.ready  = ~full;
  assign s_out.valid = out_v_r;
  assign s_out.data  = out_d_r;

  a_fifo_hold_word: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    s_out.valid && !s_out.ready |=> s_out.valid && $stable(s_out.data))
    else $error("offered word dropped or changed before taken");
endmodule

// file: logic/spi_slave_frame_port.sv
// slave serial frame port: debounce, shift, frame check, answer path
//
// How it works
// - deselected: ignore clock, data; output released
// - select start loads prepared answer word
// - rising clock shifts answer out, msb first
// - falling clock captures data input bit
// - select end: unequal or non-multiple-of-16 counts error
// - counts good: check word, else hand over
// - select is active low, spans one transfer
// - clock, data need three equal samples
// - select needs two equal samples
// - answer returned one transfer after request
// - first answer after reset is status
// - slave only, sixteen bit words
// - chained words pass through, no depth limit
// - outgoing word always carries parity lsb
// - odd parity; receive check can be disabled
// - error: discard, flag, answer status plus flag
`timescale 1ns/1ps
module spi_slave_frame_port (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_OSC_CLK,
  input  wire logic        I_SELECT_LOW_IN,
  input  wire logic        I_SCLK,
  input  wire logic        I_SDI,
  output logic             O_SDO,
  output logic             O_SDO_OE,
  input  wire logic        I_PARITY_CHECK_ENABLE,
  input  wire logic [13:0] I_PRIMARY_STATUS_WORD,
  input  wire logic        I_ANS_VALID,
  input  wire logic [14:0] I_ANS_DATA,
  output logic             O_REQ_VALID,
  output logic [14:0]      O_REQ_DATA,
  input  wire logic        I_REQ_READY,
  input  wire logic        I_ERR_CLEAR,
  output logic             O_SERIAL_ERROR_FLAG
);

  // ****************************************
  // oscillator domain reset
  // ****************************************
  logic orst1_r;   // release stage one
  logic orst_n_r;  // reset for the link logic

  // assert at once, release on the oscillator clock
  always_ff @(posedge I_OSC_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      orst1_r  <= 1'b0;
      orst_n_r <= 1'b0;
    end else begin
      orst1_r  <= 1'b1;
      orst_n_r <= orst1_r;
    end
  end

  // ****************************************
  // input filters
  // ****************************************
  logic cs_lvl;   // filtered select, low = selected
  logic sck_lvl;  // filtered serial clock
  logic sdi_lvl;  // filtered serial data

  // synchronised then debounced; edges come from filtered levels
  in_deglitch #(
    .N       (spi_frame_pkg::CS_SAMPLES),
    .RST_VAL (spi_frame_pkg::PIN_IDLE)
  ) u_cs_filt (
    .i_clk   (I_OSC_CLK),
    .i_rst_n (orst_n_r),
    .i_raw   (I_SELECT_LOW_IN),
    .o_level (cs_lvl)
  );

  in_deglitch #(
    .N       (spi_frame_pkg::SCK_SAMPLES),
    .RST_VAL (spi_frame_pkg::PIN_IDLE)
  ) u_sck_filt (
    .i_clk   (I_OSC_CLK),
    .i_rst_n (orst_n_r),
    .i_raw   (I_SCLK),
    .o_level (sck_lvl)
  );

  in_deglitch #(
    .N       (spi_frame_pkg::SCK_SAMPLES),
    .RST_VAL (spi_frame_pkg::PIN_IDLE)
  ) u_sdi_filt (
    .i_clk   (I_OSC_CLK),
    .i_rst_n (orst_n_r),
    .i_raw   (I_SDI),
    .o_level (sdi_lvl)
  );

  // ****************************************
  // link state and edge decode
  // ****************************************
  spi_frame_pkg::link_state_t state_r;    // selected or not
  spi_frame_pkg::link_state_t state_nxt;  // next link state
  logic sck_d_r;                          // previous filtered clock

  // select low opens a transfer, high closes it
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spi_frame_pkg::LINK_IDLE: begin
        if (!cs_lvl) begin
          state_nxt = spi_frame_pkg::LINK_SEL;
        end
      end
      spi_frame_pkg::LINK_SEL: begin
        if (cs_lvl) begin
          state_nxt = spi_frame_pkg::LINK_IDLE;
        end
      end
      default: begin
        state_nxt = spi_frame_pkg::LINK_IDLE;
      end
    endcase
  end

  wire in_sel    = (state_r == spi_frame_pkg::LINK_SEL);
  wire sel_start = ~in_sel & ~cs_lvl;
  wire sel_end   = in_sel & cs_lvl;
  // clock edges count only inside a transfer
  wire sck_rise  = in_sel & ~cs_lvl & sck_lvl & ~sck_d_r;
  wire sck_fall  = in_sel & ~cs_lvl & ~sck_lvl & sck_d_r;

  // state and edge history
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      state_r <= spi_frame_pkg::LINK_IDLE;
      sck_d_r <= spi_frame_pkg::PIN_IDLE;
    end else begin
      state_r <= state_nxt;
      sck_d_r <= sck_lvl;
    end
  end

  // ****************************************
  // shift registers
  // ****************************************
  logic [15:0] out_r;     // outgoing word, msb on the pin
  logic [15:0] in_r;      // incoming word, last 16 bits seen
  logic        oe_r;      // data output driven
  logic [14:0] ans_osc_r; // answer payload held at the link

  wire [15:0] ans_word = {ans_osc_r,
                          spi_frame_pkg::odd_par(ans_osc_r)};

  // load at select, then shift on every rising clock; the bit just
  // captured follows, so chained words leave one word later
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      out_r <= spi_frame_pkg::WORD_RST;
    end else if (sel_start) begin
      out_r <= ans_word;
    end else if (sck_rise) begin
      out_r <= {out_r[14:0], in_r[0]};
    end
  end

  // capture the data level on every falling clock
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      in_r <= spi_frame_pkg::WORD_RST;
    end else if (sck_fall) begin
      in_r <= {in_r[14:0], sdi_lvl};
    end
  end

  // output released whenever the link is not selected
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= (state_nxt == spi_frame_pkg::LINK_SEL);
    end
  end

  // ****************************************
  // edge counting
  // ****************************************
  logic [3:0] rise_cnt_r;  // rising edges modulo one word
  logic [3:0] fall_cnt_r;  // falling edges modulo one word
  logic       any_r;       // transfer saw a clock edge

  // filtered edges alternate, so the counts differ by at most one
  // and a modulo-16 pair is enough to judge the frame
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      rise_cnt_r <= spi_frame_pkg::CNT_RST;
      fall_cnt_r <= spi_frame_pkg::CNT_RST;
      any_r      <= 1'b0;
    end else if (sel_start) begin
      rise_cnt_r <= spi_frame_pkg::CNT_RST;
      fall_cnt_r <= spi_frame_pkg::CNT_RST;
      any_r      <= 1'b0;
    end else begin
      rise_cnt_r <= rise_cnt_r + (sck_rise ? spi_frame_pkg::CNT_ONE
                                           : spi_frame_pkg::CNT_RST);
      fall_cnt_r <= fall_cnt_r + (sck_fall ? spi_frame_pkg::CNT_ONE
                                           : spi_frame_pkg::CNT_RST);
      any_r      <= any_r | sck_rise | sck_fall;
    end
  end

  // ****************************************
  // frame check at select release
  // ****************************************
  logic        pce1_r;     // parity enable, first flop
  logic        pce2_r;     // parity enable, settled
  logic [14:0] rx_hold_r;  // accepted request payload
  logic        rx_tog_r;   // flips per accepted word
  logic        rk1_r;      // word ack, first flop
  logic        rk2_r;      // word ack, settled
  logic        err_tog_r;  // flips per interface error
  logic        rx_seen_r;  // last word pushed, also the ack
  logic [14:0] ans_hold_r; // answer on its way to the link
  logic        ans_tog_r;  // flips per answer sent

  wire rx_busy = rx_tog_r ^ rk2_r;
  wire cnt_ok  = (rise_cnt_r == fall_cnt_r) &&
                 (fall_cnt_r == spi_frame_pkg::CNT_RST);
  // odd parity: all sixteen bits xor to one
  wire par_ok  = ~pce2_r | (^in_r);
  // an earlier word still unclaimed makes this one an overrun
  wire word_ok = cnt_ok & par_ok & ~rx_busy;
  wire rx_go   = sel_end & any_r & word_ok;
  wire err_go  = sel_end & any_r & ~word_ok;

  // level crossings into the oscillator domain
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      pce1_r <= 1'b1;
      pce2_r <= 1'b1;
      rk1_r  <= 1'b0;
      rk2_r  <= 1'b0;
    end else begin
      pce1_r <= I_PARITY_CHECK_ENABLE;
      pce2_r <= pce1_r;
      rk1_r  <= rx_seen_r;
      rk2_r  <= rk1_r;
    end
  end

  // hand over a good word or signal an error; bad words vanish
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      rx_hold_r <= spi_frame_pkg::PAY_RST;
      rx_tog_r  <= 1'b0;
      err_tog_r <= 1'b0;
    end else if (rx_go) begin
      rx_hold_r <= in_r[15:1];
      rx_tog_r  <= ~rx_tog_r;
    end else if (err_go) begin
      err_tog_r <= ~err_tog_r;
    end
  end

  // ****************************************
  // answer crossing, oscillator side
  // ****************************************
  logic at1_r;      // answer toggle, first flop
  logic at2_r;      // answer toggle, settled
  logic at_seen_r;  // last answer taken, also the ack

  // take a new answer once its toggle has settled
  always_ff @(posedge I_OSC_CLK or negedge orst_n_r) begin
    if (!orst_n_r) begin
      at1_r     <= 1'b0;
      at2_r     <= 1'b0;
      at_seen_r <= 1'b0;
      ans_osc_r <= spi_frame_pkg::PAY_RST;
    end else begin
      at1_r     <= ans_tog_r;
      at2_r     <= at1_r;
      at_seen_r <= at2_r;
      if (at2_r != at_seen_r) begin
        ans_osc_r <= ans_hold_r;
      end
    end
  end

  // ****************************************
  // system side: request words
  // ****************************************
  logic rs1_r;      // word toggle, first flop
  logic rs2_r;      // word toggle, settled

  stream_if #(.W(spi_frame_pkg::PAY_W)) req_in ();
  stream_if #(.W(spi_frame_pkg::PAY_W)) req_out ();

  // a word waits here, unacknowledged, while the buffer is full
  assign req_in.valid  = rs2_r ^ rx_seen_r;
  assign req_in.data   = rx_hold_r;
  assign req_out.ready = I_REQ_READY;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rs1_r     <= 1'b0;
      rs2_r     <= 1'b0;
      rx_seen_r <= 1'b0;
    end else begin
      rs1_r <= rx_tog_r;
      rs2_r <= rs1_r;
      if (req_in.valid && req_in.ready) begin
        rx_seen_r <= rs2_r;
      end
    end
  end

  word_fifo #(
    .W (spi_frame_pkg::PAY_W),
    .D (spi_frame_pkg::FIFO_DEPTH)
  ) u_req_fifo (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .s_in    (req_in),
    .s_out   (req_out)
  );

  // ****************************************
  // system side: errors and answers
  // ****************************************
  logic        es1_r;      // error toggle, first flop
  logic        es2_r;      // error toggle, settled
  logic        err_seen_r; // last error taken
  logic        flag_r;     // sticky serial_error_flag
  logic        fresh_r;    // first cycle after reset
  logic [14:0] ans_next_r; // answer for the next transfer
  logic        pend_r;     // answer not yet sent across
  logic        ak1_r;      // answer ack, first flop
  logic        ak2_r;      // answer ack, settled

  wire err_ev = es2_r ^ err_seen_r;
  wire upd    = fresh_r | err_ev | I_ANS_VALID;
  wire send   = pend_r & ~(ak2_r ^ ans_tog_r);

  // crossings into the system domain
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      es1_r      <= 1'b0;
      es2_r      <= 1'b0;
      err_seen_r <= 1'b0;
      ak1_r      <= 1'b0;
      ak2_r      <= 1'b0;
    end else begin
      es1_r      <= err_tog_r;
      es2_r      <= es1_r;
      err_seen_r <= es2_r;
      ak1_r      <= at_seen_r;
      ak2_r      <= ak1_r;
    end
  end

  // sticky flag; a new error beats a clear in the same cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= err_ev | (flag_r & ~I_ERR_CLEAR);
    end
  end

  // status after reset, status plus flag after an error,
  // otherwise what the decoder prepared
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fresh_r    <= 1'b1;
      ans_next_r <= spi_frame_pkg::PAY_RST;
    end else begin
      fresh_r <= 1'b0;
      if (fresh_r) begin
        ans_next_r <= {1'b0, I_PRIMARY_STATUS_WORD};
      end else if (err_ev) begin
        ans_next_r <= {1'b1, I_PRIMARY_STATUS_WORD};
      end else if (I_ANS_VALID) begin
        ans_next_r <= I_ANS_DATA;
      end
    end
  end

  // send one answer at a time; hold it until acknowledged
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_r     <= 1'b0;
      ans_hold_r <= spi_frame_pkg::PAY_RST;
      ans_tog_r  <= 1'b0;
    end else begin
      pend_r <= upd | (pend_r & ~send);
      if (send) begin
        ans_hold_r <= ans_next_r;
        ans_tog_r  <= ~ans_tog_r;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_SDO               = out_r[15];
  assign O_SDO_OE            = oe_r;
  assign O_REQ_VALID         = req_out.valid;
  assign O_REQ_DATA          = req_out.data;
  assign O_SERIAL_ERROR_FLAG = flag_r;

  // ****************************************
  // checks
  // ****************************************
  a_output_released: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    !in_sel && cs_lvl |=> !oe_r)
    else $error("data output driven while deselected");

  a_answer_loaded: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    sel_start |=> out_r[15:1] == $past(ans_osc_r) && oe_r)
    else $error("answer not loaded at select");

  a_rise_shift: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    sck_rise |=> out_r == {$past(out_r[14:0]), $past(in_r[0])})
    else $error("output not advanced on rising clock");

  a_fall_capture: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    sck_fall |=> in_r[0] == $past(sdi_lvl))
    else $error("data bit not captured on falling clock");

  a_count_error: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    sel_end && any_r && (rise_cnt_r != fall_cnt_r ||
      fall_cnt_r != spi_frame_pkg::CNT_RST)
      |=> err_tog_r != $past(err_tog_r) && $stable(rx_tog_r))
    else $error("bad edge count not reported");

  a_parity_error: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    sel_end && any_r && pce2_r && !(^in_r)
      |=> $changed(err_tog_r) && $stable(rx_hold_r))
    else $error("parity failure not reported");

  a_word_handover: assert property (
    @(posedge I_OSC_CLK) disable iff (!orst_n_r)
    rx_go |=> rx_hold_r == $past(in_r[15:1]) && $changed(rx_tog_r))
    else $error("good word not handed over");

  a_first_status: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    fresh_r |=> ans_next_r == {1'b0, $past(I_PRIMARY_STATUS_WORD)}
      ##[0:3] send)
    else $error("status not sent first after reset");

  a_error_answer: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    err_ev && !fresh_r |=> flag_r && ans_next_r[14] && pend_r)
    else $error("error not flagged or not answered");

endmodule

// file: testbench/spi_master_model.sv
// serial bus master model driving the port's link pins
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic   i_clk,
  input  wire logic   i_sdo,
  output logic        o_cs_n,
  output logic        o_sclk,
  output logic        o_sdi,
  output logic [31:0] o_rx
);
  // pins idle high, as their pull-ups would hold them
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_sdi  = 1'b1;
    o_rx   = 32'h0000_0000;
  end
  // one transfer of n bits, msb first; each phase outlasts the filters
  task automatic xfer(input logic [31:0] tx, input int n);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi <= tx[i];
      repeat (8) @(posedge i_clk);
      o_rx = {o_rx[30:0], i_sdo};
      o_sclk <= 1'b0;
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_sdi  <= 1'b1;  // released line back at its pull-up level
    repeat (25) @(posedge i_clk);
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the serial frame port
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        osc_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        par_en  = 1'b1;
  logic [13:0] status  = 14'h1234;
  logic        ans_vld = 1'b0;
  logic [14:0] ans     = 15'h0000;
  logic        req_rdy = 1'b0;
  logic        err_clr = 1'b0;
  logic        cs_n, sclk, sdi, sdo, oe, req_vld, err;
  logic [14:0] req;
  logic [31:0] rx;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cyc         = 0;
  int          n;
  // rows: answer payload offered by the decoder, request payload sent
  logic [14:0] row_ans [3] = '{15'h2aaa, 15'h0001, 15'h7ffe};
  logic [14:0] row_req [3] = '{15'h0c40, 15'h5555, 15'h0000};
  always #4 sys_clk = ~sys_clk;
  // link clock with its own phase
  always begin
    #1.7;
    forever #6 osc_clk = ~osc_clk;
  end
  spi_master_model spi_master_model_inst (.i_clk(osc_clk),
    .i_sdo(oe ? sdo : ~sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi),
    .o_rx(rx));
  spi_slave_frame_port spi_slave_frame_port_inst (.I_SYS_CLK(sys_clk),
    .I_RST_N(rst_n), .I_OSC_CLK(osc_clk), .I_SELECT_LOW_IN(cs_n),
    .I_SCLK(sclk), .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(oe),
    .I_PARITY_CHECK_ENABLE(par_en), .I_PRIMARY_STATUS_WORD(status),
    .I_ANS_VALID(ans_vld), .I_ANS_DATA(ans), .O_REQ_VALID(req_vld),
    .O_REQ_DATA(req), .I_REQ_READY(req_rdy), .I_ERR_CLEAR(err_clr),
    .O_SERIAL_ERROR_FLAG(err));
  // payload plus its odd parity bit
  function automatic logic [15:0] wd(input logic [14:0] p);
    return {p, ~^p};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // decoder takes one word, bounded wait
  task automatic take(input logic [14:0] exp);
    for (n = 0; n < 300 && req_vld !== 1'b1; n++) @(posedge sys_clk) #1;
    chk(req, exp);
    req_rdy = 1'b1;
    @(posedge sys_clk) #1 req_rdy = 1'b0;
  endtask
  // decoder prepares an answer, then the master runs a transfer
  task automatic send(input logic [14:0] a, input logic [31:0] t, int b);
    ans = a;
    ans_vld = 1'b1;
    @(posedge sys_clk) #1 ans_vld = 1'b0;
    repeat (12) @(posedge osc_clk);
    spi_master_model_inst.xfer(t, b);
  endtask
  task automatic pulse_clear();
    @(posedge sys_clk) #1 err_clr = 1'b1;
    @(posedge sys_clk) #1 err_clr = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge osc_clk);
    chk(oe, 1'b0);
    spi_master_model_inst.xfer(wd(15'h0c40), 16);
    chk(rx[15:0], wd({1'b0, status}));
    take(15'h0c40);
    for (int i = 0; i < 3; i++) begin
      send(row_ans[i], wd(row_req[i]), 16);
      chk(rx[15:0], wd(row_ans[i]));
      take(row_req[i]);
    end
    send(15'h1111, {wd(15'h3333), wd(15'h4444)}, 32);
    chk(rx, {wd(15'h1111), wd(15'h3333)});
    take(15'h4444);
    send(15'h0002, wd(15'h0100) ^ 16'h0001, 16);
    chk(err, 1'b1);
    spi_master_model_inst.xfer(wd(15'h0000), 16);
    chk(rx[15:0], wd({1'b1, status}));
    take(15'h0000);
    pulse_clear();
    chk(err, 1'b0);
    spi_master_model_inst.xfer(32'h0000_00ff, 8);
    chk(err, 1'b1);
    pulse_clear();
    par_en = 1'b0;
    send(15'h0003, wd(15'h0100) ^ 16'h0001, 16);
    take(15'h0100);
    chk(err, 1'b0);
    // buffer fills, one more word waits at the link, the next overruns
    repeat (spi_frame_pkg::FIFO_DEPTH + 2)
      spi_master_model_inst.xfer(wd(15'h0055), 16);
    chk(err, 1'b1);
    #1 req_rdy = 1'b1;
    n = 0;
    repeat (100) @(negedge sys_clk) n += (req_vld === 1'b1);
    chk(n, spi_frame_pkg::FIFO_DEPTH + 1);
    // mid-run reset: outputs drop at once, status is the first answer
    req_rdy = 1'b0;
    rst_n   = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({oe, req_vld, err}, 3'b000);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge osc_clk);
    spi_master_model_inst.xfer(wd(15'h0077), 16);
    chk(rx[15:0], wd({1'b0, status}));
    take(15'h0077);
    summarize();
  end
endmodule
